// ==== mpr_chk.sv ====
`timescale 1ns/10ps
`include "mpr_regs.svh"
module mpr_chk #(
  parameter int DQ_W = 8,
  parameter int RL = 4,
  parameter int TCCD_S = 4,
  parameter int TCCD_L = 6
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Link
  input mpr_pkg::mpr_cmd_t cmd,
  input wire logic [1:0] ba,
  input wire logic [1:0] bg,
  input wire logic [`MPR_A_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_r,
  input wire logic [DQ_W-1:0] dq_f,
  input wire logic dq_oe_n,
  input wire logic dqs_hi,
  input wire logic dqs_oe_n
);
  localparam int RLM1 = RL - 1;
  logic on_q;
  logic [1:0] fmt_q;
  logic [1:0] pg_q;
  logic [3:0] gap_q;
  logic [1:0] bl_q;
  wire is_rd = cmd == mpr_pkg::MPR_CMD_RD;
  wire is_mr3 = cmd == mpr_pkg::MPR_CMD_MRS && {bg[0], ba} == 3'h3;
  // ----
  // Mode tracking
  // ----
  // Mirrors mode register 3 from the link, so format checks need no tap inside
  always_ff @(posedge CLK_SYS)
    if (!NRST)
    begin
      on_q <= 1'h0;
      fmt_q <= 2'h0;
      pg_q <= 2'h0;
    end
    else if (is_mr3)
    begin
      on_q <= addr[2];
      fmt_q <= addr[12:11];
      pg_q <= addr[1:0];
    end
  always_ff @(posedge CLK_SYS)
    if (!NRST)
      bl_q <= 2'h0;
    else if (cmd == mpr_pkg::MPR_CMD_MRS && {bg[0], ba} == 3'h0)
      bl_q <= addr[1:0];
  // Saturates, so a long idle spell never wraps into a short gap
  always_ff @(posedge CLK_SYS)
    if (!NRST)
      gap_q <= 4'hF;
    else if (is_rd)
      gap_q <= 4'h1;
    else if (gap_q != 4'hF)
      gap_q <= gap_q + 4'h1;
  // ----
  // Assertions
  // ----
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  sequence pre_s;
    !dqs_oe_n && !dqs_hi && dq_oe_n;
  endsequence
  sequence burst_s;
    (!dq_oe_n && dqs_hi && !dqs_oe_n) [*4] ##1 dq_oe_n;
  endsequence
  sequence chop_s;
    (!dq_oe_n && dqs_hi && !dqs_oe_n) [*2] ##1 (dq_oe_n && dqs_oe_n);
  endsequence
  rd_lat_a:
    assert property (is_rd |-> ##[RLM1:RL] $fell(dqs_oe_n)) else $error("read strobe not on time");
  frame_a:
    assert property ($fell(dqs_oe_n) && bl_q != 2'h2 |-> pre_s ##1 burst_s) else $error("bad read frame");
  chop_frame_a:
    assert property ($fell(dqs_oe_n) && bl_q == 2'h2 |-> pre_s ##1 chop_s) else $error("bad chopped frame");
  otf_pin_a:
    assert property (is_rd && bl_q == 2'h1 |-> addr[12]) else $error("burst pin low on fly code");
  ser_lane_a:
    assert property (!dq_oe_n && fmt_q[0] == fmt_q[1] |-> (dq_r == '0 || dq_r == '1) && (dq_f == '0 || dq_f == '1))
    else $error("serial lanes differ");
  par_rep_a:
    assert property (!dq_oe_n && fmt_q == 2'h1 |-> dq_r == dq_f ##1 (dq_oe_n || dq_r == $past(dq_r)))
    else $error("parallel beat changed");
  rd_mode_a:
    assert property (is_rd |-> on_q) else $error("read outside mode");
  rd_addr_a:
    assert property (is_rd |-> addr[1:0] == 2'h0 && (!addr[2] || bl_q == 2'h2)) else $error("bad read column");
  par_loc_a:
    assert property (is_rd && fmt_q == 2'h1 |-> ba == 2'h0) else $error("parallel read off location 0");
  rd_gap_a:
    assert property (is_rd |-> gap_q >= (pg_q == 2'h0 ? TCCD_S : TCCD_L)) else $error("reads too close");
  exit_rec_a:
    assert property (is_mr3 && !addr[2] |-> dq_oe_n && $past(dq_oe_n)) else $error("exit during burst");
endmodule

// ==== mpr_ctl.sv ====
`timescale 1ns/10ps
`include "mpr_regs.svh"
module mpr_ctl #(
  parameter int DQ_W = 8,
  parameter int TRP_NS = `MPR_TRP_NS,
  parameter int TMOD_CK = `MPR_TMOD_CK,
  parameter int TMPRR_CK = `MPR_TMPRR_CK,
  parameter int TCCD_S_CK = `MPR_TCCD_S_CK,
  parameter int TCCD_L_CK = `MPR_TCCD_L_CK
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  // AXI4-Lite write
  input wire logic [`MPR_AW-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [`MPR_AW-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Link to the device
  mpr_if.ctl LINK
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int TRP_CK = (TRP_NS + `MPR_TCK_NS - 1) / `MPR_TCK_NS;
  mpr_pkg::mpr_st_t st_q, nxt_q, start_st;
  mpr_pkg::mpr_op_t op, cop;
  logic [31:0] cmd_q;
  logic [15:0] wcnt_q;
  logic [7:0] gcnt_q;
  logic mpr_q, valid_q, err_q, bad, take, wr_go, gap_ok, cap_done;
  mpr_pkg::mpr_fmt_t fmt_q;
  logic [1:0] page_q, bl_q;
  logic [2:0] mrsel;
  logic [`MPR_A_W-1:0] mrdat;
  logic [7:0] cap_q [8];
  logic [3:0] cptr_q;
  logic [31:0] rd_mux;

  function automatic logic [7:0] low_byte(input logic [DQ_W-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 0; b < `MPR_BYTE && b < DQ_W; b++)
      r[b] = v[b];
    return r;
  endfunction

  // ----------------------------------------
  // Order checks
  // ----------------------------------------
  // Ready is gated by the enable, so a frozen slave never drops a handshake
  assign wr_go = CE && AWVALID && WVALID && !BVALID;
  assign AWREADY = wr_go;
  assign WREADY = wr_go;
  assign op = mpr_pkg::mpr_op_t'(WDATA[`MPR_C_OP]);
  assign cop = mpr_pkg::mpr_op_t'(cmd_q[`MPR_C_OP]);
  assign take = wr_go && AWADDR == `MPR_OFS_CMD && !bad;
  assign gap_ok = gcnt_q >= 8'(page_q == 2'h0 ? TCCD_S_CK : TCCD_L_CK);
  assign cap_done = st_q == mpr_pkg::MPR_ST_CAP && !LINK.dq_oe_n
    && cptr_q == (bl_q == `MPR_BC4 ? 4'h2 : 4'h6);

  always_comb
  begin
    bad = st_q != mpr_pkg::MPR_ST_IDLE || WSTRB != 4'hF;
    start_st = mpr_pkg::MPR_ST_IDLE;
    case (op)
      mpr_pkg::MPR_OP_ENTER: start_st = mpr_pkg::MPR_ST_PRE;
      mpr_pkg::MPR_OP_READ:
      begin
        start_st = mpr_pkg::MPR_ST_RD;
        bad = bad || !mpr_q || (bl_q != `MPR_BC4 && WDATA[`MPR_C_A2]);
        bad = bad || (fmt_q == mpr_pkg::MPR_FMT_PAR && WDATA[`MPR_C_LOC] != 2'h0);
        bad = bad || (page_q != 2'h0 && fmt_q != mpr_pkg::MPR_FMT_SER);
      end
      mpr_pkg::MPR_OP_EXIT:
      begin
        start_st = mpr_pkg::MPR_ST_WAIT;
        bad = bad || !mpr_q;
      end
      mpr_pkg::MPR_OP_WRITE:
      begin
        start_st = mpr_pkg::MPR_ST_WR;
        bad = bad || !mpr_q || page_q != 2'h0;
      end
      mpr_pkg::MPR_OP_MRS:
      begin
        start_st = mpr_pkg::MPR_ST_MRS;
        bad = bad || WDATA[`MPR_C_MRSEL] == `MPR_MR3;
      end
      default: bad = 1'b1;
    endcase
  end

  always_comb
  begin
    mrsel = `MPR_MR3;
    mrdat = '0;
    case (cop)
      mpr_pkg::MPR_OP_ENTER:
      begin
        mrdat[`MPR_MR3_MPR] = 1'b1;
        mrdat[`MPR_MR3_FMT] = cmd_q[`MPR_C_FMT];
        mrdat[`MPR_MR3_PAGE] = cmd_q[`MPR_C_PAGE];
      end
      mpr_pkg::MPR_OP_MRS:
      begin
        mrsel = cmd_q[`MPR_C_MRSEL];
        mrdat = cmd_q[`MPR_C_MRDAT];
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      st_q <= mpr_pkg::MPR_ST_IDLE;
      nxt_q <= mpr_pkg::MPR_ST_IDLE;
      wcnt_q <= 16'h0000;
      cmd_q <= 32'h00000000;
    end
    else if (CE)
    begin
      case (st_q)
        mpr_pkg::MPR_ST_IDLE:
        if (take)
        begin
          cmd_q <= WDATA;
          st_q <= start_st;
          wcnt_q <= 16'(TMPRR_CK);
          nxt_q <= mpr_pkg::MPR_ST_MRS;
        end
        mpr_pkg::MPR_ST_PRE:
        begin
          wcnt_q <= 16'(TRP_CK);
          nxt_q <= mpr_pkg::MPR_ST_MRS;
          st_q <= mpr_pkg::MPR_ST_WAIT;
        end
        mpr_pkg::MPR_ST_MRS, mpr_pkg::MPR_ST_WR:
        begin
          wcnt_q <= 16'(TMOD_CK);
          nxt_q <= mpr_pkg::MPR_ST_IDLE;
          st_q <= mpr_pkg::MPR_ST_WAIT;
        end
        mpr_pkg::MPR_ST_RD: if (gap_ok) st_q <= mpr_pkg::MPR_ST_CAP;
        mpr_pkg::MPR_ST_CAP: if (cap_done) st_q <= mpr_pkg::MPR_ST_IDLE;
        mpr_pkg::MPR_ST_WAIT:
        begin
          wcnt_q <= 16'(wcnt_q - 16'h0001);
          if (wcnt_q <= 16'h0001)
            st_q <= nxt_q;
        end
        default: st_q <= mpr_pkg::MPR_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Link commands and mode copies
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      LINK.cmd <= mpr_pkg::MPR_CMD_NOP;
      LINK.ba <= 2'h0;
      LINK.bg <= 2'h0;
      LINK.addr <= '0;
      mpr_q <= 1'b0;
      fmt_q <= mpr_pkg::MPR_FMT_SER;
      page_q <= 2'h0;
      bl_q <= `MPR_BL8;
    end
    else if (CE)
    begin
      LINK.cmd <= mpr_pkg::MPR_CMD_NOP;
      LINK.ba <= 2'h0;
      LINK.bg <= 2'h0;
      LINK.addr <= '0;
      case (st_q)
        mpr_pkg::MPR_ST_PRE:
        begin
          LINK.cmd <= mpr_pkg::MPR_CMD_PRE;
          LINK.addr[`MPR_A_AP] <= 1'b1;
        end
        mpr_pkg::MPR_ST_MRS:
        begin
          LINK.cmd <= mpr_pkg::MPR_CMD_MRS;
          LINK.bg[0] <= mrsel[2];
          LINK.ba <= mrsel[1:0];
          LINK.addr <= mrdat;
          if (mrsel == `MPR_MR0)
            bl_q <= mrdat[`MPR_MR0_BL];
          if (mrsel == `MPR_MR3)
          begin
            mpr_q <= mrdat[`MPR_MR3_MPR];
            fmt_q <= mpr_pkg::mpr_fmt_t'(mrdat[`MPR_MR3_FMT]);
            page_q <= mrdat[`MPR_MR3_PAGE];
          end
        end
        mpr_pkg::MPR_ST_RD:
        if (gap_ok)
        begin
          LINK.cmd <= mpr_pkg::MPR_CMD_RD;
          LINK.ba <= cmd_q[`MPR_C_LOC];
          LINK.addr[`MPR_A_A2] <= cmd_q[`MPR_C_A2] && bl_q == `MPR_BC4;
          LINK.addr[`MPR_A_BC] <= bl_q == `MPR_BLOTF;
        end
        mpr_pkg::MPR_ST_WR:
        begin
          LINK.cmd <= mpr_pkg::MPR_CMD_WR;
          LINK.ba <= cmd_q[`MPR_C_LOC];
          LINK.addr[`MPR_A_WDATA] <= cmd_q[`MPR_C_WDATA];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Read spacing and capture
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      gcnt_q <= 8'hFF;
      cptr_q <= 4'h0;
      valid_q <= 1'b0;
    end
    else if (CE)
    begin
      if (st_q == mpr_pkg::MPR_ST_RD && gap_ok)
      begin
        gcnt_q <= 8'h00;
        cptr_q <= 4'h0;
        valid_q <= 1'b0;
      end
      else if (gcnt_q != 8'hFF)
        gcnt_q <= 8'(gcnt_q + 8'h01);
      if (st_q == mpr_pkg::MPR_ST_CAP && !LINK.dq_oe_n)
      begin
        cap_q[cptr_q[2:0]] <= low_byte(LINK.dq_r);
        cap_q[3'(cptr_q[2:0] + 3'h1)] <= low_byte(LINK.dq_f);
        cptr_q <= 4'(cptr_q + 4'h2);
      end
      if (cap_done)
        valid_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (ARADDR)
      `MPR_OFS_CMD: rd_mux = cmd_q;
      `MPR_OFS_STAT:
      begin
        rd_mux[`MPR_ST_BUSY] = st_q != mpr_pkg::MPR_ST_IDLE;
        rd_mux[`MPR_ST_MPR] = mpr_q;
        rd_mux[`MPR_ST_VALID] = valid_q;
        rd_mux[`MPR_ST_ERR] = err_q;
      end
      `MPR_OFS_DLO: rd_mux = {cap_q[3], cap_q[2], cap_q[1], cap_q[0]};
      `MPR_OFS_DHI: rd_mux = {cap_q[7], cap_q[6], cap_q[5], cap_q[4]};
      default: ;
    endcase
  end

  assign ARREADY = CE && !RVALID;

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      BVALID <= 1'b0;
      BRESP <= `MPR_OKAY;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `MPR_OKAY;
      err_q <= 1'b0;
    end
    else if (CE)
    begin
      if (wr_go)
      begin
        BVALID <= 1'b1;
        BRESP <= AWADDR[`MPR_AW-1] ? `MPR_SLVERR : `MPR_OKAY;
      end
      else if (BREADY)
        BVALID <= 1'b0;
      // A refused command wins over a clear in the same write
      err_q <= (wr_go && AWADDR == `MPR_OFS_CMD && bad)
        || (err_q && !(wr_go && AWADDR == `MPR_OFS_STAT && WDATA[`MPR_ST_ERR]));
      if (ARVALID && !RVALID)
      begin
        RVALID <= 1'b1;
        RDATA <= rd_mux;
        RRESP <= ARADDR[`MPR_AW-1] ? `MPR_SLVERR : `MPR_OKAY;
      end
      else if (RREADY)
        RVALID <= 1'b0;
    end
  end
endmodule

// ==== mpr_dev.sv ====
`timescale 1ns/10ps
`include "mpr_regs.svh"
// Overview of operation
// - MPR reads use fixed BL8 or BC4 only
// - Read DBI ignored, data never inverted
// - BC4 start column is 000 or 100
// - Page 0 holds defaults after power-up
// - Written page 0 values kept until reinit
// - Page 0 reads spaced short or long
// - Pages 1 to 3 need long spacing
// - Precharge, wait, MRS sets MPR enable
// - Format code: serial, parallel, staggered, reserved
// - Page chosen by mode register 3 bits
// - Bank address selects pattern location
// - BL8 with on-the-fly code drives A12 high
// - A2 picks burst order half
// - A1:0 zero, other address pins ignored
// - Burst after additive plus CAS latency
// - Wait recovery, clear enable, wait delay
// - Non-calibration pages read in serial only
// - Strobes driven with preamble as normal
// - Serial: same byte each lane, MSB first
// - Parallel: bit 7 on DQ0, repeated
// - Parallel reads only location zero
// - x4 gives four bits, x16 repeats byte
module mpr_dev #(
  parameter int DQ_W = 8,
  parameter int AL = `MPR_AL,
  parameter int CL = `MPR_CL
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  // Link to the controller
  mpr_if.dev LINK,
  // Read-only pages 1 to 3, four bytes each
  input wire logic [`MPR_RO_W-1:0] PAGE_RO,
  // Status
  output logic MPR_MODE
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int RL = AL + CL;
  logic [7:0] pat_q [4];
  logic mpr_q;
  logic [1:0] page_q;
  mpr_pkg::mpr_fmt_t fmt_q;
  logic [1:0] bl_q;
  logic rpre2_q;
  logic [RL-1:0] pv_q;
  logic [3:0] pe_q [RL];
  logic [3:0] ent_q;
  logic [1:0] beat_q;
  logic [DQ_W-1:0] dqr_q;
  logic [DQ_W-1:0] dqf_q;
  logic [DQ_W-1:0] dqr_d;
  logic [DQ_W-1:0] dqf_d;
  logic dq_oe_n_q;
  logic dqs_oe_n_q;
  logic dqs_hi_q;
  logic rd_take;
  logic [3:0] rd_ent;
  logic [3:0] cur;
  logic [1:0] cur_beat;
  logic cur_on;
  logic drv;
  logic pre;
  logic [2:0] ui;

  // ----------------------------------------
  // Pattern source
  // ----------------------------------------
  function automatic logic [7:0] byte_of(input logic [1:0] sel);
    logic [6:0] idx;
    idx = {2'(page_q - 2'h1), sel, 3'h0};
    if (page_q == 2'h0)
      return pat_q[sel];
    return PAGE_RO[idx +: 8];
  endfunction

  function automatic logic ui_bit(input int lane, input logic [2:0] u, input logic [1:0] loc);
    logic [7:0] b;
    b = byte_of(loc);
    case (fmt_q)
      mpr_pkg::MPR_FMT_PAR: return b[`MPR_UI_MSB - 3'(lane % `MPR_BYTE)];
      mpr_pkg::MPR_FMT_STG: b = byte_of(2'(loc + 2'(lane)));
      default: ;
    endcase
    return b[`MPR_UI_MSB - u];
  endfunction

  // ----------------------------------------
  // Mode registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      mpr_q <= 1'b0;
      page_q <= 2'h0;
      fmt_q <= mpr_pkg::MPR_FMT_SER;
      bl_q <= `MPR_BL8;
      rpre2_q <= 1'b0;
    end
    else if (CE && LINK.cmd == mpr_pkg::MPR_CMD_MRS)
    begin
      case ({LINK.bg[0], LINK.ba})
        `MPR_MR0: bl_q <= LINK.addr[`MPR_MR0_BL];
        `MPR_MR3:
        begin
          mpr_q <= LINK.addr[`MPR_MR3_MPR];
          page_q <= LINK.addr[`MPR_MR3_PAGE];
          fmt_q <= mpr_pkg::mpr_fmt_t'(LINK.addr[`MPR_MR3_FMT]);
        end
        `MPR_MR4: rpre2_q <= LINK.addr[`MPR_MR4_RPRE];
        // Read DBI enable is never latched, so MPR data is never inverted
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Pattern locations of page 0
  // ----------------------------------------
  // Only reset reloads the defaults: it stands for re-initialisation
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      pat_q[0] <= `MPR_DEF0;
      pat_q[1] <= `MPR_DEF1;
      pat_q[2] <= `MPR_DEF2;
      pat_q[3] <= `MPR_DEF3;
    end
    else if (CE && mpr_q && page_q == 2'h0 && LINK.cmd == mpr_pkg::MPR_CMD_WR)
      pat_q[LINK.ba] <= LINK.addr[`MPR_A_WDATA];
  end

  // ----------------------------------------
  // Read latency pipeline
  // ----------------------------------------
  // Reads outside MPR mode are not modelled and are dropped
  assign rd_take = mpr_q && (LINK.cmd == mpr_pkg::MPR_CMD_RD || LINK.cmd == mpr_pkg::MPR_CMD_RDA);
  // Burst length comes from the fixed code only; A12 and A1:0 are not looked at
  assign rd_ent = {bl_q == `MPR_BC4, LINK.addr[`MPR_A_A2], LINK.ba};

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      pv_q <= '0;
    else if (CE)
      pv_q <= {pv_q[RL-2:0], rd_take};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (CE)
    begin
      pe_q[0] <= rd_ent;
      for (int k = 1; k < RL; k++)
        pe_q[k] <= pe_q[k-1];
    end
  end

  // ----------------------------------------
  // Burst sequencing
  // ----------------------------------------
  // A new head wins over a running burst; with four-clock spacing they never meet
  always_comb
  begin
    cur_on = pv_q[RL-1] || beat_q != 2'h0;
    cur = pv_q[RL-1] ? pe_q[RL-1] : ent_q;
    cur_beat = pv_q[RL-1] ? 2'h0 : beat_q;
    drv = cur_on && !(cur[`MPR_E_BC4] && cur_beat[1]);
    pre = pv_q[RL-2] || (rpre2_q && pv_q[RL-3]);
    ui = 3'({cur[`MPR_E_A2], 2'h0} + {cur_beat, 1'h0});
    for (int i = 0; i < DQ_W; i++)
    begin
      dqr_d[i] = drv && ui_bit(i, ui, cur[`MPR_E_LOC]);
      dqf_d[i] = drv && ui_bit(i, 3'(ui + 3'h1), cur[`MPR_E_LOC]);
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      beat_q <= 2'h0;
      ent_q <= 4'h0;
    end
    else if (CE)
    begin
      beat_q <= cur_on ? 2'(cur_beat + 2'h1) : 2'h0;
      ent_q <= cur;
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      dqr_q <= '0;
      dqf_q <= '0;
      dq_oe_n_q <= 1'b1;
      dqs_oe_n_q <= 1'b1;
      dqs_hi_q <= 1'b0;
    end
    else if (CE)
    begin
      dqr_q <= dqr_d;
      dqf_q <= dqf_d;
      dq_oe_n_q <= !drv;
      dqs_oe_n_q <= !(drv || pre);
      dqs_hi_q <= drv;
    end
  end

  assign LINK.dq_r = dqr_q;
  assign LINK.dq_f = dqf_q;
  assign LINK.dq_oe_n = dq_oe_n_q;
  assign LINK.dqs_oe_n = dqs_oe_n_q;
  assign LINK.dqs_hi = dqs_hi_q;
  assign MPR_MODE = mpr_q;
endmodule

// ==== mpr_if.sv ====
`timescale 1ns/10ps
`include "mpr_regs.svh"
interface mpr_if #(
  parameter int DQ_W = 8
);
  mpr_pkg::mpr_cmd_t cmd;
  logic [1:0] ba;
  logic [1:0] bg;
  logic [`MPR_A_W-1:0] addr;
  logic [DQ_W-1:0] dq_r;
  logic [DQ_W-1:0] dq_f;
  logic dq_oe_n;
  logic dqs_hi;
  logic dqs_oe_n;
  modport dev (input cmd, ba, bg, addr, output dq_r, dq_f, dq_oe_n, dqs_hi, dqs_oe_n);
  modport ctl (output cmd, ba, bg, addr, input dq_r, dq_f, dq_oe_n, dqs_hi, dqs_oe_n);
endinterface

// ==== mpr_pkg.sv ====
package mpr_pkg;
  typedef enum logic [2:0] {
    MPR_CMD_NOP = 3'b000,
    MPR_CMD_MRS = 3'b001,
    MPR_CMD_PRE = 3'b010,
    MPR_CMD_RD = 3'b011,
    MPR_CMD_RDA = 3'b100,
    MPR_CMD_WR = 3'b101
  } mpr_cmd_t;
  typedef enum logic [1:0] {
    MPR_FMT_SER = 2'b00,
    MPR_FMT_PAR = 2'b01,
    MPR_FMT_STG = 2'b10,
    MPR_FMT_RSV = 2'b11
  } mpr_fmt_t;
  typedef enum logic [2:0] {
    MPR_OP_ENTER = 3'b000,
    MPR_OP_READ = 3'b001,
    MPR_OP_EXIT = 3'b010,
    MPR_OP_WRITE = 3'b011,
    MPR_OP_MRS = 3'b100
  } mpr_op_t;
  typedef enum logic [2:0] {
    MPR_ST_IDLE = 3'b000,
    MPR_ST_PRE = 3'b001,
    MPR_ST_MRS = 3'b010,
    MPR_ST_RD = 3'b011,
    MPR_ST_WR = 3'b100,
    MPR_ST_WAIT = 3'b101,
    MPR_ST_CAP = 3'b110
  } mpr_st_t;
endpackage

// ==== mpr_regs.svh ====
`ifndef MPR_REGS_SVH
`define MPR_REGS_SVH
// ----------------------------------------
// Link widths and page contents
// ----------------------------------------
`define MPR_A_W 18
`define MPR_RO_W 96
`define MPR_BYTE 8
`define MPR_UI_MSB 3'h7
`define MPR_DEF0 8'h55
`define MPR_DEF1 8'h33
`define MPR_DEF2 8'h0F
`define MPR_DEF3 8'h00
// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MPR_MR0 3'h0
`define MPR_MR3 3'h3
`define MPR_MR4 3'h4
`define MPR_MR0_BL 1:0
`define MPR_MR3_PAGE 1:0
`define MPR_MR3_MPR 2
`define MPR_MR3_FMT 12:11
`define MPR_MR4_RPRE 11
`define MPR_BL8 2'h0
`define MPR_BLOTF 2'h1
`define MPR_BC4 2'h2
// ----------------------------------------
// Address pins of a command
// ----------------------------------------
`define MPR_A_A2 2
`define MPR_A_AP 10
`define MPR_A_BC 12
`define MPR_A_WDATA 7:0
// ----------------------------------------
// Device read pipeline entry
// ----------------------------------------
`define MPR_E_LOC 1:0
`define MPR_E_A2 2
`define MPR_E_BC4 3
// ----------------------------------------
// Controller registers
// ----------------------------------------
`define MPR_AW 5
`define MPR_OFS_CMD 5'h00
`define MPR_OFS_STAT 5'h04
`define MPR_OFS_DLO 5'h08
`define MPR_OFS_DHI 5'h0C
`define MPR_C_OP 2:0
`define MPR_C_LOC 4:3
`define MPR_C_FMT 6:5
`define MPR_C_PAGE 8:7
`define MPR_C_A2 9
`define MPR_C_MRSEL 13:11
`define MPR_C_MRDAT 31:14
`define MPR_C_WDATA 21:14
`define MPR_ST_BUSY 0
`define MPR_ST_MPR 1
`define MPR_ST_VALID 2
`define MPR_ST_ERR 3
`define MPR_OKAY 2'h0
`define MPR_SLVERR 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define MPR_TCK_NS 50
`define MPR_TRP_NS 15
`define MPR_TMOD_CK 24
`define MPR_TMPRR_CK 1
`define MPR_TCCD_S_CK 4
`define MPR_TCCD_L_CK 6
`define MPR_AL 0
`define MPR_CL 16
`endif

// ==== test_ddr4_mpr_read_path.sv ====
`timescale 1ns/10ps
`include "mpr_regs.svh"
module test_ddr4_mpr_read_path;
  localparam logic [33:0] F = 34'h3FFFFFFFF;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [4:0] AWADDR = 5'h00, ARADDR = 5'h00;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic [31:0] WDATA = 32'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, mpr_mode;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA, rd_w;
  logic [95:0] page_ro = 96'h0;
  logic ce = 1'h1;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] mem [4][4];
  logic [67:0] q [$];
  int n_errors = 0, num_checks = 0;
  always #25 clk_sys = ~clk_sys;
  mpr_if lnk ();
  mpr_dev #(.CL(4)) i_mpr_dev (.CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .LINK(lnk),
    .PAGE_RO(page_ro), .MPR_MODE(mpr_mode));
  mpr_ctl #(.TMOD_CK(2)) i_mpr_ctl (.CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(wstrb), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .LINK(lnk));
  mpr_chk #(.RL(4)) i_mpr_chk (.CLK_SYS(clk_sys), .NRST(nrst), .cmd(lnk.cmd), .ba(lnk.ba),
    .bg(lnk.bg), .addr(lnk.addr), .dq_r(lnk.dq_r), .dq_f(lnk.dq_f), .dq_oe_n(lnk.dq_oe_n),
    .dqs_hi(lnk.dqs_hi), .dqs_oe_n(lnk.dqs_oe_n));
  // ----
  // Checking and closing
  // ----
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [33:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clk_sys);
    if (++n > 300)
    begin
      n_errors++;
      close_out();
    end
  endtask
  // Polling reads carry a zero mask and are not counted
  task automatic pop(input logic [33:0] s);
    logic [67:0] x;
    x = q.pop_front();
    if (x[67:34] != 34'h0)
      chk(s & x[67:34], x[33:0]);
    if (x[35] && ARADDR == `MPR_OFS_STAT)
      chk({33'h0, mpr_mode}, {33'h0, x[1]});
  endtask
  always @(posedge clk_sys)
  begin
    if (BVALID === 1'h1 && BREADY)
      pop({BRESP, 32'h0});
    if (RVALID === 1'h1 && RREADY)
      pop({RRESP, RDATA});
  end
  // ----
  // Bus cycles
  // ----
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    q.push_back({34'h300000000, r, 32'h0});
    @(posedge clk_sys);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do tick(n); while ((AWREADY && WREADY) !== 1'h1);
    AWVALID <= 1'h0;
    WVALID <= 1'h0;
    do tick(n); while (BVALID !== 1'h1);
    BREADY <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [33:0] e, m);
    int n = 0;
    q.push_back({m, e});
    @(posedge clk_sys);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do tick(n); while (ARREADY !== 1'h1);
    ARVALID <= 1'h0;
    do tick(n); while (RVALID !== 1'h1);
    rd_w = RDATA;
    RREADY <= 1'h0;
  endtask
  task automatic go(input logic [31:0] w);
    int n = 0;
    wr(`MPR_OFS_CMD, w, `MPR_OKAY);
    do tick(n); while (0);
    do
    begin
      rd(`MPR_OFS_STAT, 34'h0, 34'h0);
      n++;
    end
    while (rd_w[0] !== 1'h0 && n < 60);
    if (n >= 60)
    begin
      n_errors++;
      close_out();
    end
  endtask
  function automatic logic [31:0] ew(input int f, p, l, h);
    logic [31:0] w;
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 8; i++)
        w[8 * k + i] = f == 1 ? mem[p][0][7 - i] : mem[p][f == 2 ? (l + i) % 4 : l][7 - 4 * h - k];
    return w;
  endfunction
  task automatic rdloc(input int f, p, l);
    go(32'(1 + l * 8));
    rd(`MPR_OFS_DLO, {2'h0, ew(f, p, l, 0)}, F);
    rd(`MPR_OFS_DHI, {2'h0, ew(f, p, l, 1)}, F);
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    int b, k;
    void'($urandom(32'hB3A9));
    page_ro = {$urandom, $urandom, $urandom};
    for (int i = 0; i < 12; i++)
      mem[1 + i / 4][i % 4] = page_ro[8 * i +: 8];
    mem[0] = '{`MPR_DEF0, `MPR_DEF1, `MPR_DEF2, `MPR_DEF3};
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    rd(`MPR_OFS_STAT, 34'h0, 34'hA);
    rd(5'h10, {`MPR_SLVERR, 32'h0}, F);
    wr(5'h14, 32'h0, `MPR_SLVERR);
    go(32'h1);
    rd(`MPR_OFS_STAT, 34'h8, 34'hA);
    wr(`MPR_OFS_STAT, 32'h8, `MPR_OKAY);
    rd(`MPR_OFS_STAT, 34'h0, 34'h8);
    wstrb <= 4'h7;
    go(32'h0);
    wstrb <= 4'hF;
    rd(`MPR_OFS_STAT, 34'h8, 34'hA);
    wr(`MPR_OFS_STAT, 32'h8, `MPR_OKAY);
    // Frozen slave must hold the read off until the enable returns
    ce <= 1'h0;
    fork
    begin
      repeat (4) @(posedge clk_sys);
      ce <= 1'h1;
    end
    join_none
    rd(`MPR_OFS_STAT, 34'h0, 34'h8);
    // Read inversion requested in MR5, must stay without effect
    go(32'h1 << 26 | 32'h5 << 11 | 32'h4);
    for (int f = 0; f < 4; f++)
    begin
      go(32'(f << 5));
      if (f == 0)
      begin
        b = $urandom_range(255);
        k = $urandom_range(3);
        go(32'(3 + k * 8 + b * 16384));
        mem[0][k] = 8'(b);
      end
      for (int l = 0; l < 4; l++)
        if (f != 1 || l == 0)
          rdloc(f, 0, l);
      go(32'h2);
    end
    for (int p = 1; p < 4; p++)
    begin
      go(32'(p << 7));
      for (int l = 0; l < 4; l++)
        rdloc(0, p, l);
      go(32'h2);
    end
    go(32'h20);
    go(32'h11);
    go(32'h201);
    go(32'hC0);
    go(32'h1);
    rd(`MPR_OFS_STAT, 34'hA, 34'hA);
    for (int m = 1; m < 3; m++)
    begin
      go(32'(4 + m * 16384));
      go(32'h0);
      for (int h = 0; h < m; h++)
      begin
        go(32'(1 + h * 512));
        rd(`MPR_OFS_DLO, {2'h0, ew(0, 0, 0, h)}, F);
      end
      go(32'h2);
    end
    go(32'h4);
    rd(`MPR_OFS_STAT, 34'h0, 34'h2);
    rd(`MPR_OFS_CMD, {2'h0, 32'h4}, F);
    close_out();
  end
endmodule
